// *** verilog/dfs_top.sv ***
`timescale 1ns/1ps
`include "dfs_defines.svh"
// ==========================================
// Drive fault supervisor with APB register access
module dfs_top #(
	parameter int TICK_CYCLES = `DFS_TICK_CYCLES
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic         fault_in,
	input  wire logic [7:0]   fault_code_in,
	input  wire logic [1:0]   fault_react,
	input  wire logic [15:0]  bus_voltage,
	input  wire logic [15:0]  output_current,
	input  wire logic [15:0]  actual_speed,
	input  wire logic [15:0]  set_freq,
	input  wire logic [15:0]  current_freq,
	input  wire logic [15:0]  upper_freq,
	input  wire logic [15:0]  lower_freq,
	input  wire logic [15:0]  rated_freq,
	input  wire logic         stop_done,
	output logic [15:0]       freq_cmd,
	output logic              drive_enable,
	output logic              ramp_stop,
	output logic [7:0]        fault_code,
	output logic              overspeed_fault,
	output logic              speed_deviation_fault,
	output logic              irq
);
	// ==========================================
	// Configuration registers and interrupt status
	logic              vector_closed_loop_ff;
	logic              load_loss_enable_ff;
	logic [2:0]        continue_run_freq_select_ff;
	logic [1:0]        ride_through_select_ff;
	logic [9:0]        standby_freq_percent_ff;
	logic [15:0]       maximum_frequency_setting_ff;
	logic [15:0]       bus_nominal_ff;
	logic [9:0]        bus_recovery_voltage_ff;
	logic [9:0]        ride_through_action_voltage_ff;
	logic [9:0]        bus_recovery_judge_time_ff;
	logic [9:0]        load_loss_current_level_ff;
	logic [9:0]        load_loss_detect_time_ff;
	logic [9:0]        overspeed_level_ff;
	logic [9:0]        overspeed_detect_time_ff;
	logic [9:0]        speed_dev_level_ff;
	logic [9:0]        speed_dev_detect_time_ff;
	logic [15:0]       current_rated_ff;
	logic [`DFS_IRQ_W-1:0] irq_stat_ff;
	logic [`DFS_IRQ_W-1:0] irq_mask_ff;

	logic        apb_wr;
	logic        apb_rd;
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !penable && !pwrite;

	// Register writes, zero-wait APB slave
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_closed_loop_ff          <= 1'b0;
			load_loss_enable_ff            <= 1'b0;
			continue_run_freq_select_ff    <= 3'h0;
			ride_through_select_ff         <= 2'h0;
			standby_freq_percent_ff        <= `DFS_RST_STANDBY;
			maximum_frequency_setting_ff   <= `DFS_RST_MAX_FREQ;
			bus_nominal_ff                 <= 16'h0000;
			bus_recovery_voltage_ff        <= `DFS_RST_RECOV_V;
			ride_through_action_voltage_ff <= `DFS_RST_ACTION_V;
			bus_recovery_judge_time_ff     <= `DFS_RST_RECOV_T;
			load_loss_current_level_ff     <= `DFS_RST_LL_LEVEL;
			load_loss_detect_time_ff       <= `DFS_RST_LL_TIME;
			overspeed_level_ff             <= `DFS_RST_OS_LEVEL;
			overspeed_detect_time_ff       <= `DFS_RST_OS_TIME;
			speed_dev_level_ff             <= `DFS_RST_DEV_LEVEL;
			speed_dev_detect_time_ff       <= `DFS_RST_DEV_TIME;
			current_rated_ff               <= 16'h0000;
			irq_mask_ff                    <= '0;
		end else if (apb_wr) begin
			case (paddr)
				`DFS_REG_CTRL: begin
					vector_closed_loop_ff <= pwdata[0];
					load_loss_enable_ff   <= pwdata[1];
				end
				`DFS_REG_FREQSEL: begin
					continue_run_freq_select_ff  <= pwdata[2:0];
					standby_freq_percent_ff      <= pwdata[13:4];
					maximum_frequency_setting_ff <= pwdata[31:16];
				end
				`DFS_REG_RIDE: begin
					ride_through_select_ff         <= pwdata[1:0];
					bus_recovery_voltage_ff        <= pwdata[11:2];
					ride_through_action_voltage_ff <= pwdata[21:12];
				end
				`DFS_REG_LOAD: begin
					load_loss_current_level_ff <= pwdata[9:0];
					current_rated_ff           <= pwdata[31:16];
				end
				`DFS_REG_SPEED: begin
					overspeed_level_ff <= pwdata[9:0];
					speed_dev_level_ff <= pwdata[19:10];
					bus_nominal_ff     <= {pwdata[31:20], 4'h0};
				end
				`DFS_REG_TIMES0: begin
					bus_recovery_judge_time_ff <= pwdata[9:0];
					load_loss_detect_time_ff   <= pwdata[19:10];
				end
				`DFS_REG_TIMES1: begin
					overspeed_detect_time_ff <= pwdata[9:0];
					speed_dev_detect_time_ff <= pwdata[19:10];
				end
				`DFS_REG_IRQ_MASK: irq_mask_ff <= pwdata[`DFS_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================
	// Time base: one tick per 0.1 s
	logic [31:0] tick_cnt_ff;
	logic        tick;
	assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_ff <= 32'h0;
		end else begin
			tick_cnt_ff <= tick ? 32'h0 : tick_cnt_ff + 32'h1;
		end
	end

	// ==========================================
	// Scaled thresholds, permil of a reference
	function automatic logic [15:0] dfs_scale(input logic [15:0] ref_v, input logic [9:0] pm);
		logic [25:0] prod;
		prod = ref_v * pm;
		dfs_scale = 16'(prod / 26'd1000);
	endfunction : dfs_scale
	logic [15:0] recov_thr;
	logic [15:0] dip_thr;
	logic [15:0] ll_thr;
	logic [15:0] os_thr;
	logic [15:0] dev_thr;
	logic [15:0] standby_freq;
	logic [15:0] ll_freq;
	assign recov_thr    = dfs_scale(bus_nominal_ff, bus_recovery_voltage_ff);
	assign dip_thr      = dfs_scale(bus_nominal_ff, ride_through_action_voltage_ff);
	assign ll_thr       = dfs_scale(current_rated_ff, load_loss_current_level_ff);
	assign os_thr       = dfs_scale(maximum_frequency_setting_ff, overspeed_level_ff);
	assign dev_thr      = dfs_scale(maximum_frequency_setting_ff, speed_dev_level_ff);
	assign standby_freq = dfs_scale(maximum_frequency_setting_ff, standby_freq_percent_ff);
	assign ll_freq      = dfs_scale(rated_freq, `DFS_LL_FREQ_PERMIL);
	// Monitored conditions; speed checks gated by control mode
	logic [16:0] speed_diff;
	logic [15:0] speed_abs;
	logic        cond_recov;
	logic        cond_ll;
	logic        cond_os;
	logic        cond_dev;
	assign speed_diff = {1'b0, actual_speed} - {1'b0, set_freq};
	assign speed_abs  = speed_diff[16] ? 16'(-speed_diff) : speed_diff[15:0];
	assign cond_recov = bus_voltage >= recov_thr;
	assign cond_ll    = load_loss_enable_ff && (output_current < ll_thr);
	assign cond_os    = vector_closed_loop_ff && (overspeed_detect_time_ff != 10'h000)
		&& !speed_diff[16] && (speed_diff[15:0] > os_thr);
	assign cond_dev   = vector_closed_loop_ff && (speed_dev_detect_time_ff != 10'h000)
		&& (speed_abs > dev_thr);
	logic recov_done;
	logic ll_done;
	logic os_done;
	logic dev_done;
	// One duration timer per monitored condition
	dfs_timer u_recov (.pclk(pclk), .presetn(presetn), .tick(tick), .cond(cond_recov),
		.limit(bus_recovery_judge_time_ff), .done(recov_done));
	dfs_timer u_ll (.pclk(pclk), .presetn(presetn), .tick(tick), .cond(cond_ll),
		.limit(load_loss_detect_time_ff), .done(ll_done));
	dfs_timer u_os (.pclk(pclk), .presetn(presetn), .tick(tick), .cond(cond_os),
		.limit(overspeed_detect_time_ff), .done(os_done));
	dfs_timer u_dev (.pclk(pclk), .presetn(presetn), .tick(tick), .cond(cond_dev),
		.limit(speed_dev_detect_time_ff), .done(dev_done));

	// ==========================================
	// Ride-through state: dip latches until recovery judged in mode 1, for good in modes 2 and 3
	logic dip_ff;
	logic ll_active_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dip_ff <= 1'b0;
		end else if (ride_through_select_ff == 2'h0) begin
			dip_ff <= 1'b0;
		end else if (bus_voltage < dip_thr) begin
			dip_ff <= 1'b1;
		end else if (ride_through_select_ff == 2'h1 && recov_done) begin
			dip_ff <= 1'b0;
		end
	end

	// Load-loss fallback holds until current is back above the level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ll_active_ff <= 1'b0;
		end else if (ll_done) begin
			ll_active_ff <= 1'b1;
		end else if (!cond_ll) begin
			ll_active_ff <= 1'b0;
		end
	end

	// ==========================================
	// Fault latch; speed faults join the external fault path
	logic        fault_ff;
	logic [1:0]  react_ff;
	logic        any_fault;
	assign any_fault   = fault_in || os_done || dev_done;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_ff              <= 1'b0;
			react_ff              <= 2'h0;
			fault_code            <= 8'h00;
			overspeed_fault       <= 1'b0;
			speed_deviation_fault <= 1'b0;
		end else if (any_fault && !fault_ff) begin
			fault_ff              <= 1'b1;
			react_ff              <= fault_react;
			fault_code            <= fault_in ? fault_code_in : (os_done ? 8'h2c : 8'h2d);
			overspeed_fault       <= os_done;
			speed_deviation_fault <= dev_done;
		end else if (apb_wr && paddr == `DFS_REG_STATUS && pwdata[0] && !any_fault) begin
			fault_ff              <= 1'b0;
			fault_code            <= 8'h00;
			overspeed_fault       <= 1'b0;
			speed_deviation_fault <= 1'b0;
		end
	end

	// ==========================================
	// Output drive: reaction and frequency selection
	dfs_pkg::dfs_drive_e drv;
	logic [15:0] nxt_freq;
	always_comb begin
		drv      = dfs_pkg::DFS_DRV_RUN;
		nxt_freq = set_freq;
		if (fault_ff && react_ff == 2'(dfs_pkg::DFS_REACT_FREE)) begin
			drv = dfs_pkg::DFS_DRV_COAST;
		end else if (fault_ff && react_ff != 2'(dfs_pkg::DFS_REACT_CONT)) begin
			drv = stop_done ? dfs_pkg::DFS_DRV_COAST : dfs_pkg::DFS_DRV_RAMP;
		end else if (fault_ff) begin
			case (continue_run_freq_select_ff)
				3'h0:    nxt_freq = current_freq;
				3'h1:    nxt_freq = set_freq;
				3'h2:    nxt_freq = upper_freq;
				3'h3:    nxt_freq = lower_freq;
				3'h4:    nxt_freq = standby_freq;
				default: nxt_freq = set_freq;
			endcase
		end else if (dip_ff) begin
			drv = dfs_pkg::DFS_DRV_RAMP;
		end else if (ll_active_ff) begin
			nxt_freq = ll_freq;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_cmd     <= 16'h0000;
			drive_enable <= 1'b0;
			ramp_stop    <= 1'b0;
		end else begin
			freq_cmd     <= (drv == dfs_pkg::DFS_DRV_RUN) ? nxt_freq : 16'h0000;
			drive_enable <= (drv != dfs_pkg::DFS_DRV_COAST);
			ramp_stop    <= (drv == dfs_pkg::DFS_DRV_RAMP);
		end
	end

	// ==========================================
	// Interrupts: sticky, write one to clear, set wins
	logic [`DFS_IRQ_W-1:0] irq_set;
	logic [`DFS_IRQ_W-1:0] irq_clr;
	logic                  dip_q_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dip_q_ff <= 1'b0;
		end else begin
			dip_q_ff <= dip_ff;
		end
	end
	assign irq_set = {dip_q_ff && !dip_ff, dip_ff && !dip_q_ff, ll_done && !ll_active_ff,
		dev_done, os_done, any_fault && !fault_ff};
	assign irq_clr = (apb_wr && paddr == `DFS_REG_IRQ_STAT) ? pwdata[`DFS_IRQ_W-1:0] : '0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= '0;
			irq         <= 1'b0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
			irq         <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_mask_ff);
		end
	end

	// ==========================================
	// Read data, registered in setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b1;
			pslverr <= 1'b0;
		end else begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			if (apb_rd) begin
				case (paddr)
					`DFS_REG_CTRL:     prdata <= {30'h0, load_loss_enable_ff,
						vector_closed_loop_ff};
					`DFS_REG_FREQSEL:  prdata <= {maximum_frequency_setting_ff, 2'h0,
						standby_freq_percent_ff, 1'b0, continue_run_freq_select_ff};
					`DFS_REG_RIDE:     prdata <= {10'h0, ride_through_action_voltage_ff,
						bus_recovery_voltage_ff, ride_through_select_ff};
					`DFS_REG_LOAD:     prdata <= {current_rated_ff, 6'h0,
						load_loss_current_level_ff};
					`DFS_REG_SPEED:    prdata <= {bus_nominal_ff[15:4], speed_dev_level_ff,
						overspeed_level_ff};
					`DFS_REG_TIMES0:   prdata <= {12'h0, load_loss_detect_time_ff,
						bus_recovery_judge_time_ff};
					`DFS_REG_TIMES1:   prdata <= {12'h0, speed_dev_detect_time_ff,
						overspeed_detect_time_ff};
					`DFS_REG_STATUS:   prdata <= {16'h0, fault_code, 2'h0, ll_active_ff,
						dip_ff, speed_deviation_fault, overspeed_fault, react_ff == 2'h1,
						fault_ff};
					`DFS_REG_IRQ_STAT: prdata <= {26'h0, irq_stat_ff};
					`DFS_REG_IRQ_MASK: prdata <= {26'h0, irq_mask_ff};
					`DFS_REG_FREQ_OUT: prdata <= {16'h0, freq_cmd};
					default:           prdata <= 32'h0;
				endcase
			end
		end
	end

	// ==========================================
	// Checks
	sequence s_free_fault;
		fault_ff && react_ff == 2'h0;
	endsequence
	AST_FREE_COAST: assert property (@(posedge pclk) disable iff (!presetn)
		s_free_fault |=> !drive_enable) else $error("free stop still drives");
	AST_STOP_RAMP: assert property (@(posedge pclk) disable iff (!presetn)
		fault_ff && react_ff == 2'h1 && !stop_done |=> ramp_stop) else $error("no ramp");
	AST_CODE_HELD: assert property (@(posedge pclk) disable iff (!presetn)
		fault_ff && !apb_wr |=> fault_code == $past(fault_code)) else $error("code lost");
	AST_STANDBY: assert property (@(posedge pclk) disable iff (!presetn)
		fault_ff && react_ff == 2'h2 && continue_run_freq_select_ff == 3'h4
		|=> freq_cmd == $past(standby_freq)) else $error("standby freq wrong");
	AST_MODE2_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		dip_ff && ride_through_select_ff == 2'h2 |=> dip_ff) else $error("mode 2 reaccel");
	AST_LL_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		!load_loss_enable_ff |-> !ll_done) else $error("load loss while disabled");
	AST_OS_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		!vector_closed_loop_ff |-> !os_done && !dev_done) else $error("speed check open loop");
	AST_DEV_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		speed_dev_detect_time_ff == 10'h000 |-> !dev_done) else $error("dev time zero");
	AST_OS_RAISE: assert property (@(posedge pclk) disable iff (!presetn)
		os_done && !fault_ff |=> fault_ff && overspeed_fault) else $error("no overspeed");
endmodule : dfs_top

// *** verilog/dfs_defines.svh ***
`ifndef DFS_DEFINES_SVH
`define DFS_DEFINES_SVH
// Functional notes
// - A fault with free-stop reaction shows its code and drops drive output at once.
// - A fault with stop-mode reaction shows its code, ramps down and keeps the code.
// - A fault with continue reaction keeps running at the frequency picked by the selector.
// - Selector 4 runs at standby percent times maximum frequency, 0.0 to 100.0 percent; the 10-bit field takes up to 102.3 percent unclamped.
// - Ride-through mode 1 ramps down on a bus dip and back up to set frequency on recovery.
// - The bus counts as recovered only after being normal longer than the judgment time.
// - Recovery is judged against a threshold of 80 to 100 percent, default 85 percent; the 10-bit field takes 0.0 to 102.3 percent unclamped.
// - Ride-through mode 2 ramps down to standstill and never reaccelerates.
// - Load-loss detection works only while its one-bit enable is set.
// - Load-loss level is 0.0 to 100.0 percent, default 10; detect time 0.0 to 60.0 s; the 10-bit fields take up to 102.3 percent and 102.3 s.
// - Current below the level longer than the detect time cuts frequency to 7 percent rated.
// - During load-loss reduction the set frequency returns once the load recovers.
// - Overspeed and deviation checks run only in closed-loop vector control.
// - Speed above set by more than the overspeed level longer than its time raises overspeed.
// - Speed off set by more than the deviation level longer than its time raises deviation.
// - A detect time of zero disables overspeed or deviation detection.

// ==========================================
// Register map
`define DFS_REG_CTRL      12'h000
`define DFS_REG_FREQSEL   12'h004
`define DFS_REG_RIDE      12'h008
`define DFS_REG_LOAD      12'h00c
`define DFS_REG_SPEED     12'h010
`define DFS_REG_TIMES0    12'h014
`define DFS_REG_TIMES1    12'h018
`define DFS_REG_STATUS    12'h01c
`define DFS_REG_IRQ_STAT  12'h020
`define DFS_REG_IRQ_MASK  12'h024
`define DFS_REG_FREQ_OUT  12'h028

// ==========================================
// Reset values, percent in tenths, times in tenths of a second
`define DFS_RST_STANDBY      10'd1000
`define DFS_RST_RECOV_V      10'd850
`define DFS_RST_ACTION_V     10'd800
`define DFS_RST_RECOV_T      10'd5
`define DFS_RST_LL_LEVEL     10'd100
`define DFS_RST_LL_TIME      10'd10
`define DFS_RST_OS_LEVEL     10'd200
`define DFS_RST_OS_TIME      10'd10
`define DFS_RST_DEV_LEVEL    10'd200
`define DFS_RST_DEV_TIME     10'd50
`define DFS_RST_MAX_FREQ     16'h1388
`define DFS_LL_FREQ_PERMIL   10'd70
`define DFS_PERMIL_FULL      10'd1000

// ==========================================
// Timing: one time unit is 0.1 s at 40 MHz
`define DFS_CLK_HZ           40000000
`define DFS_TICK_MS          100
`define DFS_TICK_CYCLES      ((`DFS_CLK_HZ / 1000) * `DFS_TICK_MS)

// ==========================================
// Interrupt bits
`define DFS_IRQ_FAULT        0
`define DFS_IRQ_OVERSPEED    1
`define DFS_IRQ_DEVIATION    2
`define DFS_IRQ_LOADLOSS     3
`define DFS_IRQ_DIP          4
`define DFS_IRQ_RECOVER      5
`define DFS_IRQ_W            6
`endif

// *** verilog/dfs_pkg.sv ***
package dfs_pkg;
	typedef enum logic [1:0] {
		DFS_REACT_FREE,
		DFS_REACT_STOP,
		DFS_REACT_CONT,
		DFS_REACT_RSVD
	} dfs_react_e;

	typedef enum logic [1:0] {
		DFS_DRV_RUN,
		DFS_DRV_COAST,
		DFS_DRV_RAMP
	} dfs_drive_e;

	typedef logic [15:0] dfs_freq_t;
	typedef logic [9:0]  dfs_permil_t;
endpackage : dfs_pkg

// *** verilog/dfs_timer.sv ***
`timescale 1ns/1ps
`include "dfs_defines.svh"
// ==========================================
// Duration timer: asserts done once cond held longer than limit ticks
module dfs_timer (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       tick,
	input  wire logic       cond,
	input  wire logic [9:0] limit,
	output logic            done
);
	logic [10:0] cnt_ff;

	// Counter restarts whenever the condition drops; spare bit avoids a wrap at full limit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 11'h000;
		end else if (!cond) begin
			cnt_ff <= 11'h000;
		end else if (tick && cnt_ff <= {1'b0, limit}) begin
			cnt_ff <= cnt_ff + 11'h001;
		end
	end

	// Strictly longer than limit: one tick past it
	assign done = cond && (cnt_ff > {1'b0, limit});

	AST_TIMER_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		!cond |=> cnt_ff == 11'h000) else $error("timer not cleared");
endmodule : dfs_timer

// *** verification/dfs_plant_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Plant: bus sensing, load current and shaft speed follow bench targets
module dfs_plant_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [15:0] bus_tgt,
	input  wire logic [15:0] cur_tgt,
	input  wire logic [15:0] spd_tgt,
	input  wire logic        ramp_stop,
	input  wire logic        drive_enable,
	output logic      [15:0] bus_voltage,
	output logic      [15:0] output_current,
	output logic      [15:0] actual_speed,
	output logic             stop_done
);
	logic [3:0] stop_cnt_ff;
	// Sensors lag one cycle, like a sampled measurement path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_voltage    <= 16'h0640;
			output_current <= 16'h01f4;
			actual_speed   <= 16'h07d0;
		end else begin
			bus_voltage    <= bus_tgt;
			output_current <= cur_tgt;
			actual_speed   <= spd_tgt;
		end
	end
	// Ramp never ends at once; a stopped motor stays at rest until the drive runs again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stop_cnt_ff <= 4'h0;
		else if (drive_enable && !ramp_stop)
			stop_cnt_ff <= 4'h0;
		else if (ramp_stop && stop_cnt_ff != 4'h8)
			stop_cnt_ff <= stop_cnt_ff + 4'h1;
	end
	assign stop_done = (stop_cnt_ff == 4'h8);
endmodule : dfs_plant_model

// *** verification/dfs_top_tb_top.sv ***
`timescale 1ns/1ps
`include "dfs_defines.svh"
module dfs_top_tb_top;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, fault_in = 1'b0, stop_done, ramp_stop, drive_enable, irq;
	logic        overspeed_fault, speed_deviation_fault;
	logic [7:0]  fault_code_in = 8'h00, fault_code;
	logic [1:0]  fault_react = 2'h2;
	logic [15:0] bus_voltage, output_current, actual_speed, freq_cmd;
	logic [15:0] set_freq = 16'h07d0, current_freq = 16'h05dc, upper_freq = 16'h0fa0;
	logic [15:0] lower_freq = 16'h012c, rated_freq = 16'h03e8;
	logic [15:0] bus_tgt = 16'h0640, cur_tgt = 16'h01f4, spd_tgt = 16'h07d0;
	logic [15:0] exp_sel [5] = '{16'h05dc, 16'h07d0, 16'h0fa0, 16'h012c, 16'h09c4};
	int          num_errors = 0, check_count = 0, cyc_cnt = 0;

	always #12.5 pclk = ~pclk;

	// Short tick keeps every duration timer within a few dozen cycles
	dfs_top #(.TICK_CYCLES(10)) dfs_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .fault_in, .fault_code_in, .fault_react,
		.bus_voltage, .output_current, .actual_speed, .set_freq, .current_freq, .upper_freq,
		.lower_freq, .rated_freq, .stop_done, .freq_cmd, .drive_enable, .ramp_stop, .fault_code,
		.overspeed_fault, .speed_deviation_fault, .irq);
	dfs_plant_model dfs_plant_model_inst (.pclk, .presetn, .bus_tgt, .cur_tgt, .spd_tgt,
		.ramp_stop, .drive_enable, .bus_voltage, .output_current, .actual_speed, .stop_done);

	// ==========================================
	// Bench tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	// One APB transfer; an idle edge first keeps back-to-back calls legal
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rd & m, e);
		chk({nm, " err"}, {31'h0, pslverr}, 32'h0);
	endtask : rchk
	// Source drops first; a clear while it is active would be ignored
	task automatic clr();
		fault_in <= 1'b0;
		apb(1'b1, `DFS_REG_STATUS, 32'h1);
		cyc(2);
	endtask : clr
	task automatic end_of_test();
		if (num_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test

	// ==========================================
	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge pclk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	// ==========================================
	// Test sequence
	initial begin
		cyc(20);
		presetn <= 1'b1;
		rchk("freqsel", `DFS_REG_FREQSEL, 32'hffff_3ff0, 32'h1388_3e80);
		rchk("ride", `DFS_REG_RIDE, 32'h003f_fffc, 32'h0032_0d48);
		rchk("load", `DFS_REG_LOAD, 32'h0000_03ff, 32'h0000_0064);
		rchk("times0", `DFS_REG_TIMES0, 32'h000f_ffff, 32'h0000_2805);
		rchk("times1", `DFS_REG_TIMES1, 32'h000f_ffff, 32'h0000_c80a);
		rchk("ctrl", `DFS_REG_CTRL, 32'h0000_0002, 32'h0000_0000);
		rchk("unmapped", 12'h100, 32'hffff_ffff, 32'h0000_0000);
		apb(1'b1, `DFS_REG_LOAD, 32'h03e8_0064);
		apb(1'b1, `DFS_REG_SPEED, 32'h0643_20c8);
		apb(1'b1, `DFS_REG_TIMES0, 32'h0000_0802);
		apb(1'b1, `DFS_REG_TIMES1, 32'h0000_0002);
		// Continue reaction through every frequency source
		for (int s = 0; s < 5; s++) begin
			apb(1'b1, `DFS_REG_FREQSEL, 32'h1388_1f40 | 32'(s));
			fault_code_in <= 8'h10 + 8'(s);
			fault_in <= 1'b1;
			cyc(4);
			chk("cont freq", {16'h0, freq_cmd}, {16'h0, exp_sel[s]});
			chk("cont run", {31'h0, drive_enable}, 32'h1);
			chk("cont code", {24'h0, fault_code}, {24'h0, 8'h10 + 8'(s)});
			clr();
		end
		fault_react <= 2'h0;
		fault_code_in <= 8'h21;
		fault_in <= 1'b1;
		cyc(3);
		chk("free enable", {31'h0, drive_enable}, 32'h0);
		chk("free freq", {16'h0, freq_cmd}, 32'h0);
		chk("free code", {24'h0, fault_code}, 32'h21);
		clr();
		fault_react <= 2'h1;
		fault_code_in <= 8'h22;
		fault_in <= 1'b1;
		cyc(3);
		chk("ramp stop", {31'h0, ramp_stop}, 32'h1);
		cyc(20);
		chk("stopped", {31'h0, drive_enable}, 32'h0);
		rchk("stop status", `DFS_REG_STATUS, 32'h0000_ff03, 32'h0000_2203);
		clr();
		fault_react <= 2'h2;
		// Load loss: disabled first, then short dips, then a long one
		cur_tgt <= 16'h0032;
		cyc(60);
		chk("ll off", {16'h0, freq_cmd}, 32'h07d0);
		cur_tgt <= 16'h01f4;
		apb(1'b1, `DFS_REG_CTRL, 32'h2);
		repeat (2) begin
			cur_tgt <= 16'h0032;
			cyc(15);
			cur_tgt <= 16'h01f4;
			cyc(2);
		end
		chk("ll restart", {16'h0, freq_cmd}, 32'h07d0);
		cur_tgt <= 16'h0032;
		cyc(40);
		chk("ll cut", {16'h0, freq_cmd}, 32'h0046);
		rchk("freq out", `DFS_REG_FREQ_OUT, 32'h0000_ffff, 32'h0000_0046);
		cur_tgt <= 16'h01f4;
		cyc(4);
		chk("ll back", {16'h0, freq_cmd}, 32'h07d0);
		// Speed faults: open loop ignored, then each check with the other off
		apb(1'b1, `DFS_REG_CTRL, 32'h0);
		spd_tgt <= 16'h0dac;
		cyc(60);
		chk("os open", {31'h0, overspeed_fault}, 32'h0);
		apb(1'b1, `DFS_REG_CTRL, 32'h1);
		cyc(40);
		chk("os set", {31'h0, overspeed_fault}, 32'h1);
		chk("os code", {24'h0, fault_code}, 32'h2c);
		chk("dev off", {31'h0, speed_deviation_fault}, 32'h0);
		spd_tgt <= 16'h07d0;
		clr();
		apb(1'b1, `DFS_REG_TIMES1, 32'h0000_0800);
		spd_tgt <= 16'h01f4;
		cyc(40);
		chk("dev set", {31'h0, speed_deviation_fault}, 32'h1);
		chk("dev code", {24'h0, fault_code}, 32'h2d);
		chk("os off", {31'h0, overspeed_fault}, 32'h0);
		spd_tgt <= 16'h07d0;
		clr();
		apb(1'b1, `DFS_REG_CTRL, 32'h0);
		// Ride-through with dip interrupt raised, cleared and masked
		apb(1'b1, `DFS_REG_IRQ_STAT, 32'h3f);
		apb(1'b1, `DFS_REG_IRQ_MASK, 32'h10);
		apb(1'b1, `DFS_REG_RIDE, 32'h0032_0d49);
		bus_tgt <= 16'h03e8;
		cyc(4);
		chk("dip freq", {16'h0, freq_cmd}, 32'h0);
		chk("dip irq", {31'h0, irq}, 32'h1);
		apb(1'b1, `DFS_REG_IRQ_STAT, 32'h10);
		cyc(2);
		chk("irq clr", {31'h0, irq}, 32'h0);
		bus_tgt <= 16'h0514;
		cyc(60);
		chk("below recov", {16'h0, freq_cmd}, 32'h0);
		bus_tgt <= 16'h0578;
		cyc(15);
		chk("judge early", {16'h0, freq_cmd}, 32'h0);
		cyc(30);
		chk("recovered", {16'h0, freq_cmd}, 32'h07d0);
		apb(1'b1, `DFS_REG_IRQ_MASK, 32'h0);
		apb(1'b1, `DFS_REG_RIDE, 32'h0032_0d4a);
		bus_tgt <= 16'h03e8;
		cyc(4);
		chk("irq masked", {31'h0, irq}, 32'h0);
		rchk("dip stat", `DFS_REG_IRQ_STAT, 32'h10, 32'h10);
		bus_tgt <= 16'h0640;
		cyc(60);
		chk("no reaccel", {16'h0, freq_cmd}, 32'h0);
		end_of_test();
	end
endmodule : dfs_top_tb_top
